// ==== core/lle_pkg.sv ====
// Shared types and constants for link layer error injection
package lle_pkg;

  // ****************************************************************
  // Test vector span and widths
  // ****************************************************************
  localparam int VEC_LSB = 15;
  localparam int VEC_MSB = 28;
  localparam int SEQ_W   = 12;
  localparam int HDR_W   = 8;
  localparam int DATA_W  = 12;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  // Receive DLLP forcing selection
  localparam logic [1:0] RXF_NONE   = 2'h0;
  localparam logic [1:0] RXF_ACKNAK = 2'h1;
  localparam logic [1:0] RXF_PM     = 2'h2;
  localparam logic [1:0] RXF_FC     = 2'h3;
  // ACK to NAK substitution modes
  localparam logic [1:0] AN_NONE    = 2'h0;
  localparam logic [1:0] AN_SAME    = 2'h1;
  localparam logic [1:0] AN_INC     = 2'h2;
  localparam logic [1:0] AN_DEC     = 2'h3;
  // Transmit DLLP CRC corruption selection
  localparam logic [1:0] TXC_NONE   = 2'h0;
  localparam logic [1:0] TXC_PM     = 2'h1;
  localparam logic [1:0] TXC_FC     = 2'h2;
  localparam logic [1:0] TXC_ACK    = 2'h3;
  // Credit error codes
  localparam logic [4:0] UFC_NONE         = 5'h00;
  localparam logic [4:0] UFC_FIRST_SINGLE = 5'h01;
  localparam logic [4:0] CRD_POST_BOTH    = 5'h03;
  localparam logic [4:0] UFC_NEG_INDEX    = 5'h09;
  localparam logic [4:0] CRD_CPL_DATA_DEC = 5'h11;
  localparam logic [4:0] CRD_CPL_BOTH_DEC = 5'h12;
  localparam logic [4:0] UFC_FIRST_MIXED  = 5'h13;
  localparam logic [4:0] UFC_LAST         = 5'h18;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DK_ACKNAK = 2'h0, DK_PM = 2'h1, DK_FC = 2'h2, DK_OTHER = 2'h3
  } lle_dllp_kind_t;

  typedef enum logic [1:0] {
    FC_POSTED = 2'h0, FC_NONPOSTED = 2'h1,
    FC_COMPLETION = 2'h2, FC_NONE = 2'h3
  } lle_fc_class_t;

  typedef enum logic [2:0] {
    ARM_IDLE = 3'h1, ARM_WAIT = 3'h2, ARM_DONE = 3'h4
  } lle_arm_t;

  // Test vector bits 28 down to 15
  typedef struct packed {
    logic [4:0] ufc;
    logic [1:0] dllp_crc;
    logic       lcrc;
    logic       ecrc;
    logic [1:0] acknak;
    logic       replay;
    logic [1:0] rx_dllp;
  } lle_test_t;

  typedef struct packed {
    logic [HDR_W-1:0]  hdr;
    logic [DATA_W-1:0] data;
  } lle_credit_t;

  typedef struct packed {
    lle_fc_class_t cls;
    lle_credit_t   cred;
  } lle_fc_upd_t;

  typedef struct packed {
    logic             nak;
    logic [SEQ_W-1:0] seq;
  } lle_ack_t;

  typedef struct packed {
    lle_fc_class_t cls;
    logic [1:0]    hdr;
    logic [1:0]    data;
  } lle_delta_t;

endpackage

// ==== core/lle_rx_dllp_force.sv ====
// One-shot forcing of a CRC error on the next received DLLP of the selected kind
`timescale 1ns/100ps
`default_nettype none
module lle_rx_dllp_force (
  // Clock and reset
  input  wire logic                    clk_sys_in,
  input  wire logic                    reset_in,
  // Selection
  input  wire logic                    enable_in,
  input  wire logic [1:0]              sel_in,
  // Received DLLP observation
  input  wire logic                    dllp_valid_in,
  input  wire lle_pkg::lle_dllp_kind_t dllp_kind_in,
  // Force pulse
  output logic                         force_out
);

  // Maps a selection code to the DLLP kind it names
  function automatic logic kind_match(input logic [1:0] sel,
                                      input lle_pkg::lle_dllp_kind_t k);
    case (sel)
      lle_pkg::RXF_ACKNAK: kind_match = (k == lle_pkg::DK_ACKNAK);
      lle_pkg::RXF_PM:     kind_match = (k == lle_pkg::DK_PM);
      lle_pkg::RXF_FC:     kind_match = (k == lle_pkg::DK_FC);
      default:             kind_match = 1'h0;
    endcase
  endfunction

  lle_pkg::lle_arm_t state;
  lle_pkg::lle_arm_t next_state;
  logic [1:0]        want;
  logic [1:0]        next_want;
  logic              next_force;

  always_comb begin
    next_state = state;
    next_want  = want;
    next_force = 1'h0;
    case (state)
      lle_pkg::ARM_IDLE: begin
        if (enable_in && sel_in != lle_pkg::RXF_NONE) begin
          next_state = lle_pkg::ARM_WAIT;
          next_want  = sel_in;
        end
      end
      lle_pkg::ARM_WAIT: begin
        if (!enable_in || sel_in != want) begin
          next_state = lle_pkg::ARM_IDLE;
        end else if (dllp_valid_in && kind_match(want, dllp_kind_in)) begin
          next_force = 1'h1;
          next_state = lle_pkg::ARM_DONE;
        end
      end
      lle_pkg::ARM_DONE: begin
        if (!enable_in || sel_in != want) begin
          next_state = lle_pkg::ARM_IDLE;
        end
      end
      default: next_state = lle_pkg::ARM_IDLE;
    endcase
  end

  // Registers the arming state
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state     <= lle_pkg::ARM_IDLE;
      want      <= lle_pkg::RXF_NONE;
      force_out <= 1'h0;
    end else begin
      state     <= next_state;
      want      <= next_want;
      force_out <= next_force;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_hit;
    state == lle_pkg::ARM_WAIT && enable_in && sel_in == want &&
    dllp_valid_in && kind_match(want, dllp_kind_in);
  endsequence

  a_force_hit: assert property (
    s_hit |=> force_out ##1 !force_out)
    else $error("selected DLLP not forced");
  a_force_cause: assert property (
    force_out |-> $past(dllp_valid_in) && $past(sel_in) != 2'h0)
    else $error("force without selected DLLP");

endmodule
`default_nettype wire

// ==== core/lle_credit_adjust.sv ====
// Credit error injection on flow control updates
`timescale 1ns/100ps
`default_nettype none
module lle_credit_adjust (
  // Clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 reset_in,
  // Error code
  input  wire logic [4:0]           code_in,
  // Update from the receive buffer
  input  wire logic                 upd_valid_in,
  input  wire logic                 from_extract_in,
  input  wire lle_pkg::lle_fc_upd_t upd_in,
  // Update toward the transmitter
  output logic                      upd_valid_out,
  output lle_pkg::lle_fc_upd_t      upd_out
);

  // Decodes a code into class and header and data steps
  function automatic lle_pkg::lle_delta_t ufc_decode(input logic [4:0] c);
    lle_pkg::lle_delta_t d;
    logic [4:0] idx;
    logic [4:0] grp;
    logic [1:0] unit;
    d.cls  = lle_pkg::FC_NONE;
    d.hdr  = 2'h0;
    d.data = 2'h0;
    idx    = 5'h00;
    grp    = 5'h00;
    unit   = 2'h1;
    if (c >= lle_pkg::UFC_FIRST_SINGLE && c < lle_pkg::UFC_FIRST_MIXED) begin
      idx    = c - lle_pkg::UFC_FIRST_SINGLE;
      grp    = (idx / 5'h03) % 5'h03;
      unit   = (idx >= lle_pkg::UFC_NEG_INDEX) ? 2'h3 : 2'h1;
      d.cls  = lle_pkg::lle_fc_class_t'(grp[1:0]);
      d.hdr  = ((idx % 5'h03) != 5'h01) ? unit : 2'h0;
      d.data = ((idx % 5'h03) != 5'h00) ? unit : 2'h0;
    end else if (c >= lle_pkg::UFC_FIRST_MIXED && c <= lle_pkg::UFC_LAST) begin
      idx    = c - lle_pkg::UFC_FIRST_MIXED;
      grp    = idx >> 1;
      d.cls  = lle_pkg::lle_fc_class_t'(grp[1:0]);
      d.hdr  = idx[0] ? 2'h3 : 2'h1;
      d.data = idx[0] ? 2'h1 : 2'h3;
    end
    return d;
  endfunction

  lle_pkg::lle_delta_t  dlt;
  lle_pkg::lle_fc_upd_t next_upd;
  logic                 next_valid;

  always_comb begin
    dlt        = ufc_decode(code_in);
    next_valid = upd_valid_in;
    next_upd   = upd_in;
    if (upd_valid_in && from_extract_in && dlt.cls == upd_in.cls) begin
      next_upd.cred.hdr  = upd_in.cred.hdr +
                           {{(lle_pkg::HDR_W-2){dlt.hdr[1]}}, dlt.hdr};
      next_upd.cred.data = upd_in.cred.data +
                           {{(lle_pkg::DATA_W-2){dlt.data[1]}}, dlt.data};
    end
  end

  // Registers the outgoing update
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      upd_valid_out <= 1'h0;
      upd_out       <= {lle_pkg::FC_NONE, 8'h00, 12'h000};
    end else begin
      upd_valid_out <= next_valid;
      upd_out       <= next_upd;
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_hit(logic [4:0] c, lle_pkg::lle_fc_class_t k);
    upd_valid_in && from_extract_in && code_in == c && upd_in.cls == k;
  endsequence

  a_post_both: assert property (
    s_hit(lle_pkg::CRD_POST_BOTH, lle_pkg::FC_POSTED) |=>
      upd_out.cred.hdr == $past(upd_in.cred.hdr) + 8'h01 &&
      upd_out.cred.data == $past(upd_in.cred.data) + 12'h001)
    else $error("posted credits not raised by one");
  a_cpl_data: assert property (
    s_hit(lle_pkg::CRD_CPL_DATA_DEC, lle_pkg::FC_COMPLETION) |=>
      upd_out.cred.hdr == $past(upd_in.cred.hdr) &&
      upd_out.cred.data == $past(upd_in.cred.data) - 12'h001)
    else $error("completion data credit not lowered alone");
  a_cpl_both: assert property (
    s_hit(lle_pkg::CRD_CPL_BOTH_DEC, lle_pkg::FC_COMPLETION) |=>
      upd_out.cred.hdr == $past(upd_in.cred.hdr) - 8'h01 &&
      upd_out.cred.data == $past(upd_in.cred.data) - 12'h001)
    else $error("completion credits not lowered by one");
  a_upd_clean: assert property (
    upd_valid_in && (code_in == 5'h00 || !from_extract_in) |=>
      upd_valid_out && upd_out == $past(upd_in))
    else $error("update altered without injection");

endmodule
`default_nettype wire

// ==== core/lle_core.sv ====
// Data link layer error injection driven by the test vector
`timescale 1ns/100ps
`default_nettype none
module lle_core #(
  parameter bit EIGHT_LANE = 1'h0
) (
  // Clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     reset_in,
  // Static test vector, bits 28 down to 15
  input  wire logic [lle_pkg::VEC_MSB:lle_pkg::VEC_LSB] test_vector_in,
  // Received DLLP observation
  input  wire logic                     rx_dllp_valid_in,
  input  wire lle_pkg::lle_dllp_kind_t  rx_dllp_kind_in,
  output logic                          rx_dllp_crc_force_out,
  // Retry buffer
  output logic                          replay_start_out,
  // Outgoing ACK
  input  wire logic                     tx_ack_valid_in,
  input  wire lle_pkg::lle_ack_t        tx_ack_in,
  output logic                          tx_ack_valid_out,
  output lle_pkg::lle_ack_t             tx_ack_out,
  // Outgoing TLP
  input  wire logic                     tx_tlp_valid_in,
  output logic                          tx_ecrc_corrupt_out,
  output logic                          tx_lcrc_corrupt_out,
  // Outgoing DLLP
  input  wire logic                     tx_dllp_valid_in,
  input  wire lle_pkg::lle_dllp_kind_t  tx_dllp_kind_in,
  output logic                          tx_dllp_crc_corrupt_out,
  // Flow control update
  input  wire logic                     fc_upd_valid_in,
  input  wire logic                     fc_from_extract_in,
  input  wire lle_pkg::lle_fc_upd_t     fc_upd_in,
  output logic                          fc_upd_valid_out,
  output lle_pkg::lle_fc_upd_t          fc_upd_out
);

  // ****************************************************************
  // Test vector fields
  // ****************************************************************
  lle_pkg::lle_test_t vec;
  logic               narrow;

  // Splits the vector and gates fields reserved on eight lanes
  // There they read as normal mode; the ECRC and credit error fields still act
  assign vec    = lle_pkg::lle_test_t'(test_vector_in);
  assign narrow = ~EIGHT_LANE;

  // Tells whether a transmitted DLLP kind is the one selected
  function automatic logic tx_match(input logic [1:0] sel,
                                    input lle_pkg::lle_dllp_kind_t k);
    case (sel)
      lle_pkg::TXC_PM:  tx_match = (k == lle_pkg::DK_PM);
      lle_pkg::TXC_FC:  tx_match = (k == lle_pkg::DK_FC);
      lle_pkg::TXC_ACK: tx_match = (k == lle_pkg::DK_ACKNAK);
      default:          tx_match = 1'h0;
    endcase
  endfunction

  // ****************************************************************
  // Receive DLLP forcing
  // ****************************************************************
  // arm on selection
  lle_rx_dllp_force u_rx_force (
    .clk_sys_in    (clk_sys_in),
    .reset_in      (reset_in),
    .enable_in     (narrow),
    .sel_in        (vec.rx_dllp),
    .dllp_valid_in (rx_dllp_valid_in),
    .dllp_kind_in  (rx_dllp_kind_in),
    .force_out     (rx_dllp_crc_force_out)
  );

  // ****************************************************************
  // Replay request
  // ****************************************************************
  logic replay_q;
  logic next_replay_q;
  logic next_replay_start;

  // A held bit must not replay again and again, so only its rise
  // counts; a bit already high as reset ends still starts one replay
  // rising edge starts
  always_comb begin
    next_replay_q     = vec.replay & narrow;
    next_replay_start = next_replay_q & ~replay_q;
  end

  // Registers the level and the start pulse
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      replay_q         <= 1'h0;
      replay_start_out <= 1'h0;
    end else begin
      replay_q         <= next_replay_q;
      replay_start_out <= next_replay_start;
    end
  end

  // ****************************************************************
  // ACK to NAK substitution
  // ****************************************************************
  lle_pkg::lle_ack_t next_ack;
  logic              next_ack_valid;

  // Sequence numbers wrap at 12 bits, as the link counts them
  // NAK replaces ACK
  always_comb begin
    next_ack_valid = tx_ack_valid_in;
    next_ack       = tx_ack_in;
    if (tx_ack_valid_in && narrow) begin
      case (vec.acknak)
        lle_pkg::AN_SAME: begin
          next_ack.nak = 1'h1;
        end
        lle_pkg::AN_INC: begin
          next_ack.nak = 1'h1;
          next_ack.seq = tx_ack_in.seq + 12'h001;
        end
        lle_pkg::AN_DEC: begin
          next_ack.nak = 1'h1;
          next_ack.seq = tx_ack_in.seq - 12'h001;
        end
        default: next_ack = tx_ack_in;
      endcase
    end
  end

  // Registers the acknowledge toward the transmitter
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_ack_valid_out <= 1'h0;
      tx_ack_out       <= {1'h0, 12'h000};
    end else begin
      tx_ack_valid_out <= next_ack_valid;
      tx_ack_out       <= next_ack;
    end
  end

  // ****************************************************************
  // Transmit CRC corruption
  // ****************************************************************
  logic next_ecrc;
  logic next_lcrc;
  logic next_dllp_crc;

  // Marks packets that leave with a bad CRC
  // Strobes follow the packet by one cycle, as on the ACK path
  always_comb begin
    next_ecrc     = tx_tlp_valid_in & vec.ecrc;
    next_lcrc     = tx_tlp_valid_in & vec.lcrc & narrow;
    next_dllp_crc = tx_dllp_valid_in & narrow &
                    tx_match(vec.dllp_crc, tx_dllp_kind_in);
  end

  // Registers the corruption strobes
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tx_ecrc_corrupt_out     <= 1'h0;
      tx_lcrc_corrupt_out     <= 1'h0;
      tx_dllp_crc_corrupt_out <= 1'h0;
    end else begin
      tx_ecrc_corrupt_out     <= next_ecrc;
      tx_lcrc_corrupt_out     <= next_lcrc;
      tx_dllp_crc_corrupt_out <= next_dllp_crc;
    end
  end

  // ****************************************************************
  // Flow control credit errors
  // ****************************************************************
  // Only updates from extraction toward the application change
  // wrong credit values
  lle_credit_adjust u_credit (
    .clk_sys_in      (clk_sys_in),
    .reset_in        (reset_in),
    .code_in         (vec.ufc),
    .upd_valid_in    (fc_upd_valid_in),
    .from_extract_in (fc_from_extract_in),
    .upd_in          (fc_upd_in),
    .upd_valid_out   (fc_upd_valid_out),
    .upd_out         (fc_upd_out)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  sequence s_ack(logic [1:0] mode);
    tx_ack_valid_in && narrow && vec.acknak == mode;
  endsequence

  sequence s_dllp(logic [1:0] sel, lle_pkg::lle_dllp_kind_t k);
    tx_dllp_valid_in && narrow && vec.dllp_crc == sel &&
    tx_dllp_kind_in == k;
  endsequence

  a_replay_edge: assert property (
    $rose(vec.replay) && narrow |=> replay_start_out ##1 !replay_start_out)
    else $error("replay start not a single pulse");
  a_replay_cause: assert property (
    replay_start_out |-> $past(vec.replay) &&
      (!$past(vec.replay, 2) || $past(reset_in, 2)))
    else $error("replay start without rising input");
  a_nak_same: assert property (
    s_ack(lle_pkg::AN_SAME) |=>
      tx_ack_out.nak && tx_ack_out.seq == $past(tx_ack_in.seq))
    else $error("NAK with same number wrong");
  a_nak_inc: assert property (
    s_ack(lle_pkg::AN_INC) |=>
      tx_ack_out.nak && tx_ack_out.seq == $past(tx_ack_in.seq) + 12'h001)
    else $error("NAK with incremented number wrong");
  a_nak_dec: assert property (
    s_ack(lle_pkg::AN_DEC) |=>
      tx_ack_out.nak && tx_ack_out.seq == $past(tx_ack_in.seq) - 12'h001)
    else $error("NAK with decremented number wrong");
  a_ack_clean: assert property (
    tx_ack_valid_in && vec.acknak == lle_pkg::AN_NONE |=>
      tx_ack_valid_out && tx_ack_out == $past(tx_ack_in))
    else $error("ACK altered in normal mode");
  a_ecrc_mark: assert property (
    tx_tlp_valid_in |=> tx_ecrc_corrupt_out == $past(vec.ecrc))
    else $error("ECRC error not injected as selected");
  a_ecrc_idle: assert property (
    !tx_tlp_valid_in |=> !tx_ecrc_corrupt_out)
    else $error("ECRC error without packet");
  a_lcrc_mark: assert property (
    tx_tlp_valid_in && narrow |=> tx_lcrc_corrupt_out == $past(vec.lcrc))
    else $error("LCRC error not injected as selected");
  a_dllp_pm: assert property (
    s_dllp(lle_pkg::TXC_PM, lle_pkg::DK_PM) |=> tx_dllp_crc_corrupt_out)
    else $error("PM DLLP CRC not corrupted");
  a_dllp_fc: assert property (
    s_dllp(lle_pkg::TXC_FC, lle_pkg::DK_FC) |=> tx_dllp_crc_corrupt_out)
    else $error("flow control DLLP CRC not corrupted");
  a_dllp_ack: assert property (
    s_dllp(lle_pkg::TXC_ACK, lle_pkg::DK_ACKNAK) |=>
      tx_dllp_crc_corrupt_out)
    else $error("ACK DLLP CRC not corrupted");
  a_dllp_quiet: assert property (
    vec.dllp_crc == lle_pkg::TXC_NONE |=> !tx_dllp_crc_corrupt_out)
    else $error("DLLP CRC corrupted in normal mode");

  // Valid strobes pass one cycle later whatever the mode
  a_ack_valid: assert property (
    tx_ack_valid_in |=> tx_ack_valid_out)
    else $error("ACK strobe lost");
  a_ack_none: assert property (
    !tx_ack_valid_in |=> !tx_ack_valid_out)
    else $error("ACK strobe without input");
  a_fc_valid: assert property (
    fc_upd_valid_in |=> fc_upd_valid_out)
    else $error("credit update lost");
  a_fc_none: assert property (
    !fc_upd_valid_in |=> !fc_upd_valid_out)
    else $error("credit update without input");
  a_fc_class: assert property (
    fc_upd_valid_in |=> fc_upd_out.cls == $past(fc_upd_in.cls))
    else $error("credit update class altered");

  // Corruption strobes only with a packet of the selected kind
  a_lcrc_idle: assert property (
    !tx_tlp_valid_in |=> !tx_lcrc_corrupt_out)
    else $error("LCRC error without packet");
  a_dllp_idle: assert property (
    !tx_dllp_valid_in |=> !tx_dllp_crc_corrupt_out)
    else $error("DLLP CRC corrupted without DLLP");
  a_dllp_other: assert property (
    tx_dllp_valid_in && tx_dllp_kind_in == lle_pkg::DK_OTHER |=>
      !tx_dllp_crc_corrupt_out)
    else $error("unselected DLLP CRC corrupted");

  // Replay and receive forcing stay single pulses
  a_replay_once: assert property (
    replay_start_out |=> !replay_start_out)
    else $error("replay start longer than one cycle");
  a_rx_once: assert property (
    rx_dllp_crc_force_out |=> !rx_dllp_crc_force_out)
    else $error("receive force longer than one cycle");
  a_rx_idle: assert property (
    !rx_dllp_valid_in |=> !rx_dllp_crc_force_out)
    else $error("receive force without DLLP");
  a_rx_new_sel: assert property (
    $changed(vec.rx_dllp) |=> !rx_dllp_crc_force_out)
    else $error("DLLP forced as selection changed");

endmodule
`default_nettype wire

// ==== test/lle_test_logic.sv ====
// Model of the user test logic that drives the static test vector
`timescale 1ns/100ps
`default_nettype none
module lle_test_logic (
  // Field settings from the bench
  input  wire lle_pkg::lle_test_t                   fields_in,
  // Vector toward the core
  output logic [lle_pkg::VEC_MSB:lle_pkg::VEC_LSB]  vector_out
);
  // unused fields zero
  // Fields stay zero unless a test sets them
  assign vector_out = fields_in;
endmodule
`default_nettype wire

// ==== test/lle_core_tb.sv ====
// Self-checking bench for the link layer error injection core
`timescale 1ns/100ps
`default_nettype none
module lle_core_tb;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                                    clk_sys_in = 1'h0;
  logic                                    reset_in = 1'h1;
  lle_pkg::lle_test_t                      fields = '0;
  logic [lle_pkg::VEC_MSB:lle_pkg::VEC_LSB] vec;
  logic                                    rx_v = 1'h0;
  lle_pkg::lle_dllp_kind_t                 rx_k = lle_pkg::DK_OTHER;
  logic                                    ack_vi = 1'h0;
  lle_pkg::lle_ack_t                       ack_i = '0;
  logic                                    tlp_v = 1'h0;
  logic                                    dl_v = 1'h0;
  lle_pkg::lle_dllp_kind_t                 dl_k = lle_pkg::DK_OTHER;
  logic                                    fc_vi = 1'h0;
  logic                                    fc_x = 1'h0;
  lle_pkg::lle_fc_upd_t                    fc_i = '0;
  logic                                    rx_frc;
  logic                                    replay;
  logic                                    ack_vo;
  lle_pkg::lle_ack_t                       ack_o;
  logic                                    ecrc;
  logic                                    lcrc;
  logic                                    dcrc;
  logic                                    fc_vo;
  lle_pkg::lle_fc_upd_t                    fc_o;
  int                                      mismatches = 0;
  int                                      total_checks = 0;
  int                                      cycles = 0;

  // Clock of 100 ns
  always #50 clk_sys_in = ~clk_sys_in;

  lle_test_logic model_u (.fields_in(fields), .vector_out(vec));

  lle_core dut_u (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .test_vector_in(vec),
    .rx_dllp_valid_in(rx_v), .rx_dllp_kind_in(rx_k),
    .rx_dllp_crc_force_out(rx_frc), .replay_start_out(replay),
    .tx_ack_valid_in(ack_vi), .tx_ack_in(ack_i),
    .tx_ack_valid_out(ack_vo), .tx_ack_out(ack_o),
    .tx_tlp_valid_in(tlp_v), .tx_ecrc_corrupt_out(ecrc),
    .tx_lcrc_corrupt_out(lcrc), .tx_dllp_valid_in(dl_v),
    .tx_dllp_kind_in(dl_k), .tx_dllp_crc_corrupt_out(dcrc),
    .fc_upd_valid_in(fc_vi), .fc_from_extract_in(fc_x), .fc_upd_in(fc_i),
    .fc_upd_valid_out(fc_vo), .fc_upd_out(fc_o)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Wait edges, then land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Received DLLP of a kind, expect force or not
  task automatic rx_try(input lle_pkg::lle_dllp_kind_t k, input logic exp);
    rx_k = k;
    rx_v = 1'h1;
    step(1);
    rx_v = 1'h0;
    check_flag(rx_frc, exp);
    step(1);
  endtask

  // Outgoing ACK under a mode, expect the word sent
  task automatic ack_try(input logic [1:0] m, input logic [11:0] s,
                         input logic [12:0] exp);
    fields.acknak = m;
    ack_i = {1'h0, s};
    ack_vi = 1'h1;
    step(1);
    ack_vi = 1'h0;
    check_flag(ack_vo, 1'h1);
    check_word(32'(ack_o), 32'(exp));
    step(1);
  endtask

  // Outgoing TLP with both CRC injection bits set as given
  task automatic tlp_try(input logic e, input logic l);
    fields.ecrc = e;
    fields.lcrc = l;
    tlp_v = 1'h1;
    step(1);
    tlp_v = 1'h0;
    check_flag(ecrc, e);
    check_flag(lcrc, l);
    step(1);
  endtask

  // Outgoing DLLP of a kind, expect corruption or not
  task automatic dl_try(input lle_pkg::lle_dllp_kind_t k, input logic exp);
    dl_k = k;
    dl_v = 1'h1;
    step(1);
    dl_v = 1'h0;
    check_flag(dcrc, exp);
    step(1);
  endtask

  // Credit update of header 10 and data 20, expect the given credits
  task automatic fc_try(input logic [4:0] c, input logic x,
                        input lle_pkg::lle_fc_class_t cl,
                        input logic [7:0] eh, input logic [11:0] ed);
    fields.ufc = c;
    fc_x = x;
    fc_i = {cl, 8'h10, 12'h020};
    fc_vi = 1'h1;
    step(1);
    fc_vi = 1'h0;
    check_flag(fc_vo, 1'h1);
    check_word(32'(fc_o), 32'({cl, eh, ed}));
    step(1);
  endtask

  // Hang guard
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      close_out();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    step(16);
    reset_in = 1'h0;
    check_word(32'(fc_o), 32'({lle_pkg::FC_NONE, 20'h00000}));
    for (int s = 1; s < 4; s++) begin
      fields.rx_dllp = 2'(s);
      step(3);
      rx_try(lle_pkg::DK_OTHER, 1'h0);
      rx_try(lle_pkg::lle_dllp_kind_t'(s - 1), 1'h1);
      rx_try(lle_pkg::lle_dllp_kind_t'(s - 1), 1'h0);
      fields.rx_dllp = 2'h0;
      step(2);
    end
    fields.replay = 1'h1;
    step(1);
    check_flag(replay, 1'h1);
    step(1);
    check_flag(replay, 1'h0);
    fields.replay = 1'h0;
    ack_try(2'h0, 12'h005, 13'h0005);
    ack_try(2'h1, 12'h005, 13'h1005);
    ack_try(2'h2, 12'hfff, 13'h1000);
    ack_try(2'h3, 12'h000, 13'h1fff);
    fields.acknak = 2'h0;
    tlp_try(1'h1, 1'h0);
    tlp_try(1'h0, 1'h1);
    tlp_try(1'h0, 1'h0);
    for (int m = 1; m < 4; m++) begin
      fields.dllp_crc = 2'(m);
      step(1);
      dl_try(lle_pkg::DK_OTHER, 1'h0);
      dl_try(lle_pkg::lle_dllp_kind_t'(m % 3), 1'h1);
    end
    fields.dllp_crc = 2'h0;
    fc_try(5'h03, 1'h1, lle_pkg::FC_POSTED, 8'h11, 12'h021);
    fc_try(5'h03, 1'h0, lle_pkg::FC_POSTED, 8'h10, 12'h020);
    fc_try(5'h11, 1'h1, lle_pkg::FC_COMPLETION, 8'h10, 12'h01f);
    fc_try(5'h12, 1'h1, lle_pkg::FC_COMPLETION, 8'h0f, 12'h01f);
    fc_try(5'h12, 1'h1, lle_pkg::FC_POSTED, 8'h10, 12'h020);
    fc_try(5'h00, 1'h1, lle_pkg::FC_COMPLETION, 8'h10, 12'h020);
    close_out();
  end
endmodule
`default_nettype wire
